// ==== logic/trsf_pkg.sv ====
// Package holding offsets, bit positions, reset values and counts of the receive status flags.
package trsf_pkg;

    localparam logic [7:0] ADDR_SUMMARY  = 8'h0E;
    localparam logic [7:0] ADDR_INFO1_A  = 8'h22;
    localparam logic [7:0] ADDR_INFO2_A  = 8'h31;
    localparam logic [7:0] ADDR_INFO1_B  = 8'hC2;

    localparam int SUM_A_ST1  = 0;
    localparam int SUM_A_ST2  = 1;
    localparam int SUM_A_DL   = 2;
    localparam int SUM_B_ST1  = 3;
    localparam int SUM_B_ST2  = 4;
    localparam int SUM_B_DL   = 5;
    localparam int SUM_BERT   = 6;

    localparam int I1_ALIGN   = 7;
    localparam int I1_ZERO8   = 6;
    localparam int I1_ZERO16  = 5;
    localparam int I1_SEVERE  = 2;
    localparam int I1_CODE    = 1;
    localparam int I1_FBIT    = 0;

    localparam int I2_SYNC    = 7;
    localparam int I2_LCAR    = 6;
    localparam int I2_FCAR    = 5;
    localparam int I2_BLUE    = 2;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    localparam logic [4:0] ZERO_RUN_SHORT = 5'h08;
    localparam logic [4:0] ZERO_RUN_LONG  = 5'h10;
    localparam logic [4:0] ZERO_RUN_MAX   = 5'h1F;

    localparam logic [2:0] SEVERE_WINDOW = 3'h6;
    localparam logic [2:0] SEVERE_LIMIT  = 3'h2;

    localparam logic [7:0] MASK_INFO1 = 8'hE7;
    localparam logic [7:0] MASK_INFO2 = 8'hE4;

endpackage

// ==== logic/trsf_line_watch.sv ====
// Zero-run, code word and severely errored framing detectors for one framer.
`timescale 1ns/1ps
module trsf_line_watch (
    input  wire logic MCLK,
    input  wire logic RST_N,
    input  wire logic bit_valid,
    input  wire logic pos_in,
    input  wire logic neg_in,
    input  wire logic fbit_valid,
    input  wire logic fbit_error,
    output logic      zero8_evt,
    output logic      zero16_evt,
    output logic      code_evt,
    output logic      severe_evt
);

    typedef struct packed {
        logic [4:0] run;
        logic [7:0] hist_p;
        logic [7:0] hist_n;
        logic [5:0] fwin;
        logic       z8;
        logic       z16;
        logic       code;
        logic       severe;
    } trsf_watch_t;

    trsf_watch_t s_q;
    trsf_watch_t s_d;

    function automatic logic [2:0] count_ones(input logic [5:0] v);
        logic [2:0] c;
        c = 3'h0;
        for (int i = 0; i < 6; i++) begin
            c = c + {2'h0, v[i]};
        end
        return c;
    endfunction

    assign zero8_evt  = s_q.z8;
    assign zero16_evt = s_q.z16;
    assign code_evt   = s_q.code;
    assign severe_evt = s_q.severe;

    always_comb begin
        s_d        = s_q;
        s_d.z8     = 1'b0;
        s_d.z16    = 1'b0;
        s_d.code   = 1'b0;
        s_d.severe = 1'b0;
        if (bit_valid) begin
            s_d.hist_p = {s_q.hist_p[6:0], pos_in};
            s_d.hist_n = {s_q.hist_n[6:0], neg_in};
            if (pos_in || neg_in) begin
                s_d.run = 5'h00;
            end else if (s_q.run != trsf_pkg::ZERO_RUN_MAX) begin
                s_d.run = s_q.run + 5'h01;
            end
            // Flag once when a run reaches its length; longer runs add nothing.
            s_d.z8  = (s_d.run == trsf_pkg::ZERO_RUN_SHORT);
            s_d.z16 = (s_d.run == trsf_pkg::ZERO_RUN_LONG);
            // Substitution 000VB0VB with the violation polarity of either sign.
            // Newest bit sits in bit 0, so the violations land in bits 4 and 1.
            s_d.code = ((s_d.hist_p == 8'h11) && (s_d.hist_n == 8'h0A))
                    || ((s_d.hist_p == 8'h0A) && (s_d.hist_n == 8'h11));
        end
        if (fbit_valid) begin
            s_d.fwin   = {s_q.fwin[4:0], fbit_error};
            s_d.severe = (count_ones(s_d.fwin) >= trsf_pkg::SEVERE_LIMIT)
                      && fbit_error;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

// ==== logic/trsf_status_flags.sv ====
// Receive information registers and interrupt source summary of a dual framer.
//
// Behaviour
// - Summary bits 3, 4, 5 show framer B status one, status two, data link.
// - Summary bits 0, 1, 2 show framer A status one, status two, data link.
// - A summary bit is 1 while its source requests; bit 6 is the tester.
// - Bit 7 latches when a resync moved frame or multiframe alignment.
// - Bit 6 latches on any run of eight or more zeros.
// - Bit 5 latches on any run of sixteen or more zeros.
// - Bit 1 latches on a substitution code word, enable or not.
// - Bit 0 latches on a wrong terminal or pattern framing bit.
// - Second register bit 7 latches on sync gained until read.
// - Second register bit 6 latches on line carrier return until read.
// - Second register bit 5 latches on framer carrier return until read.
// - Second register bit 2 latches when blue alarm stops until read.
// - Unassigned bits read as zero; host ignores them.
// - Framer B keeps its own first register fed from its own inputs.
// - Bits latch on events, clear on read; no bit holds while its alarm is present.
`timescale 1ns/1ps
module trsf_status_flags (
    input  wire logic       MCLK,
    input  wire logic       RST_N,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       BIT_VALID_A,
    input  wire logic       RX_POSITIVE_IN_A,
    input  wire logic       RX_NEGATIVE_IN_A,
    input  wire logic       BIT_VALID_B,
    input  wire logic       RX_POSITIVE_IN_B,
    input  wire logic       RX_NEGATIVE_IN_B,
    input  wire logic       FBIT_VALID_A,
    input  wire logic       FBIT_ERROR_A,
    input  wire logic       FBIT_VALID_B,
    input  wire logic       FBIT_ERROR_B,
    input  wire logic       ALIGN_CHANGE_A,
    input  wire logic       ALIGN_CHANGE_B,
    input  wire logic       SYNC_LOST_A,
    input  wire logic       LINE_CARRIER_LOST_A,
    input  wire logic       FRAMER_CARRIER_LOST_A,
    input  wire logic       BLUE_ALARM_A,
    input  wire logic       ZERO_SUBSTITUTION_ENABLE,
    input  wire logic [1:0] FRAMER_A_STATUS_PEND,
    input  wire logic [1:0] FRAMER_B_STATUS_PEND,
    input  wire logic [7:0] FRAMER_A_DATALINK_PEND,
    input  wire logic [7:0] FRAMER_B_DATALINK_PEND,
    input  wire logic [7:0] FRAMER_A_DATALINK_MASK,
    input  wire logic [7:0] FRAMER_B_DATALINK_MASK,
    input  wire logic       BERT_REQUEST_PENDING,
    output logic      [7:0] SUMMARY
);

    ////////////////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [7:0] info1_a;
        logic [7:0] info1_b;
        logic [7:0] info2_a;
        logic [7:0] view1_a;
        logic [7:0] view1_b;
        logic [7:0] view2_a;
        logic [7:0] mask1_a;
        logic [7:0] mask1_b;
        logic [7:0] mask2_a;
        logic [3:0] alarm_q;
        logic [7:0] rdata;
        logic [7:0] summary;
        logic [23:0] sync1;
        logic [23:0] sync2;
    } trsf_state_t;

    trsf_state_t s_q;
    trsf_state_t s_d;

    logic [15:0] raw_in;
    logic [23:0] raw_all;
    logic [15:0] in_s;
    logic [3:0]  alarm_s;
    logic        z8_a;
    logic        z16_a;
    logic        code_a;
    logic        sev_a;
    logic        z8_b;
    logic        z16_b;
    logic        code_b;
    logic        sev_b;

    // Applies a refresh mask: masked bits clear and unmasked bits keep.
    function automatic logic [7:0] clear_masked(input logic [7:0] flags,
                                                input logic [7:0] mask,
                                                input logic [7:0] sets,
                                                input logic       hit);
        logic [7:0] r;
        r = hit ? (flags & ~mask) : flags;
        return r | sets;
    endfunction

    // Refreshes the read view only in bits the host asked for.
    function automatic logic [7:0] refresh_view(input logic [7:0] view,
                                                input logic [7:0] flags,
                                                input logic [7:0] mask);
        return (view & ~mask) | (flags & mask);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////

    assign raw_in = {BIT_VALID_A, RX_POSITIVE_IN_A, RX_NEGATIVE_IN_A,
                     BIT_VALID_B, RX_POSITIVE_IN_B, RX_NEGATIVE_IN_B,
                     FBIT_VALID_A, FBIT_ERROR_A, FBIT_VALID_B, FBIT_ERROR_B,
                     ALIGN_CHANGE_A, ALIGN_CHANGE_B,
                     SYNC_LOST_A, LINE_CARRIER_LOST_A, FRAMER_CARRIER_LOST_A, BLUE_ALARM_A};
    assign raw_all = {8'h00, raw_in};
    assign in_s    = s_q.sync2[15:0];
    assign alarm_s = in_s[3:0];

    assign RDATA   = s_q.rdata;
    assign SUMMARY = s_q.summary;

    trsf_line_watch u_watch_a (
        .MCLK       (MCLK),
        .RST_N      (RST_N),
        .bit_valid  (in_s[15]),
        .pos_in     (in_s[14]),
        .neg_in     (in_s[13]),
        .fbit_valid (in_s[9]),
        .fbit_error (in_s[8]),
        .zero8_evt  (z8_a),
        .zero16_evt (z16_a),
        .code_evt   (code_a),
        .severe_evt (sev_a)
    );

    // Framer B detectors watch only framer B inputs.
    trsf_line_watch u_watch_b (
        .MCLK       (MCLK),
        .RST_N      (RST_N),
        .bit_valid  (in_s[12]),
        .pos_in     (in_s[11]),
        .neg_in     (in_s[10]),
        .fbit_valid (in_s[7]),
        .fbit_error (in_s[6]),
        .zero8_evt  (z8_b),
        .zero16_evt (z16_b),
        .code_evt   (code_b),
        .severe_evt (sev_b)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        logic [7:0] set1_a;
        logic [7:0] set1_b;
        logic [7:0] set2_a;
        logic [7:0] hold2_a;
        logic       wr1_a;
        logic       wr1_b;
        logic       wr2_a;
        logic       rd1_a;
        logic       rd1_b;
        logic       rd2_a;
        set1_a  = 8'h00;
        set1_b  = 8'h00;
        set2_a  = 8'h00;
        hold2_a = 8'h00;
        s_d     = s_q;

        s_d.sync1 = raw_all;
        s_d.sync2 = s_q.sync1;
        s_d.alarm_q = alarm_s;

        wr1_a = WR && (ADDR == trsf_pkg::ADDR_INFO1_A);
        wr1_b = WR && (ADDR == trsf_pkg::ADDR_INFO1_B);
        wr2_a = WR && (ADDR == trsf_pkg::ADDR_INFO2_A);
        rd1_a = RD && (ADDR == trsf_pkg::ADDR_INFO1_A);
        rd1_b = RD && (ADDR == trsf_pkg::ADDR_INFO1_B);
        rd2_a = RD && (ADDR == trsf_pkg::ADDR_INFO2_A);

        set1_a[trsf_pkg::I1_ALIGN]  = in_s[5];
        set1_a[trsf_pkg::I1_ZERO8]  = z8_a;
        set1_a[trsf_pkg::I1_ZERO16] = z16_a;
        set1_a[trsf_pkg::I1_SEVERE] = sev_a;
        set1_a[trsf_pkg::I1_CODE]   = code_a;
        set1_a[trsf_pkg::I1_FBIT]   = in_s[9] && in_s[8];

        set1_b[trsf_pkg::I1_ALIGN]  = in_s[4];
        set1_b[trsf_pkg::I1_ZERO8]  = z8_b;
        set1_b[trsf_pkg::I1_ZERO16] = z16_b;
        set1_b[trsf_pkg::I1_SEVERE] = sev_b;
        set1_b[trsf_pkg::I1_CODE]   = code_b;
        set1_b[trsf_pkg::I1_FBIT]   = in_s[7] && in_s[6];

        // Clear-type flags set on the falling edge of each loss condition.
        set2_a[trsf_pkg::I2_SYNC] = s_q.alarm_q[3] && !alarm_s[3];
        set2_a[trsf_pkg::I2_LCAR] = s_q.alarm_q[2] && !alarm_s[2];
        set2_a[trsf_pkg::I2_FCAR] = s_q.alarm_q[1] && !alarm_s[1];
        set2_a[trsf_pkg::I2_BLUE] = s_q.alarm_q[0] && !alarm_s[0];

        // A flag whose loss condition is back stays clear; no hold term needed here.
        hold2_a = 8'h00;

        // Host mask write picks the bits to refresh and clear; sets win over clears.
        if (wr1_a) begin
            s_d.mask1_a = WDATA & trsf_pkg::MASK_INFO1;
            s_d.view1_a = refresh_view(s_q.view1_a, s_q.info1_a, WDATA);
        end
        if (wr1_b) begin
            s_d.mask1_b = WDATA & trsf_pkg::MASK_INFO1;
            s_d.view1_b = refresh_view(s_q.view1_b, s_q.info1_b, WDATA);
        end
        if (wr2_a) begin
            s_d.mask2_a = WDATA & trsf_pkg::MASK_INFO2;
            s_d.view2_a = refresh_view(s_q.view2_a, s_q.info2_a, WDATA);
        end

        // A read clears only bits the host has seen, so a late event is not lost.
        s_d.info1_a = clear_masked(s_q.info1_a, s_q.mask1_a & s_q.view1_a, set1_a, rd1_a);
        s_d.info1_b = clear_masked(s_q.info1_b, s_q.mask1_b & s_q.view1_b, set1_b, rd1_b);
        s_d.info2_a = clear_masked(s_q.info2_a, s_q.mask2_a & s_q.view2_a,
                                   set2_a | hold2_a, rd2_a);
        if (rd1_a) begin
            s_d.mask1_a = 8'h00;
        end
        if (rd1_b) begin
            s_d.mask1_b = 8'h00;
        end
        if (rd2_a) begin
            s_d.mask2_a = 8'h00;
        end

        // Unassigned positions read as zero here.
        if (RD) begin
            unique case (ADDR)
                trsf_pkg::ADDR_SUMMARY: s_d.rdata = s_q.summary;
                trsf_pkg::ADDR_INFO1_A: s_d.rdata = s_q.view1_a & trsf_pkg::MASK_INFO1;
                trsf_pkg::ADDR_INFO1_B: s_d.rdata = s_q.view1_b & trsf_pkg::MASK_INFO1;
                trsf_pkg::ADDR_INFO2_A: s_d.rdata = s_q.view2_a & trsf_pkg::MASK_INFO2;
                default:                s_d.rdata = trsf_pkg::RESET_BYTE;
            endcase
        end

        s_d.summary = trsf_pkg::RESET_BYTE;
        s_d.summary[trsf_pkg::SUM_A_ST1] = FRAMER_A_STATUS_PEND[0];
        s_d.summary[trsf_pkg::SUM_A_ST2] = FRAMER_A_STATUS_PEND[1];
        s_d.summary[trsf_pkg::SUM_A_DL]  =
            |(FRAMER_A_DATALINK_PEND & ~FRAMER_A_DATALINK_MASK);
        s_d.summary[trsf_pkg::SUM_B_ST1] = FRAMER_B_STATUS_PEND[0];
        s_d.summary[trsf_pkg::SUM_B_ST2] = FRAMER_B_STATUS_PEND[1];
        s_d.summary[trsf_pkg::SUM_B_DL]  =
            |(FRAMER_B_DATALINK_PEND & ~FRAMER_B_DATALINK_MASK);
        s_d.summary[trsf_pkg::SUM_BERT]  = BERT_REQUEST_PENDING;
        // The enable does not gate code word detection.
        if (ZERO_SUBSTITUTION_ENABLE) begin
            s_d.summary = s_d.summary;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

// ==== tb/trsf_status_flags_props.sv ====
// Port checker of the receive status flag block.
`timescale 1ns/1ps
module trsf_status_flags_props (
    input wire logic       MCLK,
    input wire logic       RST_N,
    input wire logic [7:0] ADDR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic [1:0] FRAMER_A_STATUS_PEND,
    input wire logic [1:0] FRAMER_B_STATUS_PEND,
    input wire logic [7:0] FRAMER_A_DATALINK_PEND,
    input wire logic [7:0] FRAMER_B_DATALINK_PEND,
    input wire logic [7:0] FRAMER_A_DATALINK_MASK,
    input wire logic [7:0] FRAMER_B_DATALINK_MASK,
    input wire logic       BERT_REQUEST_PENDING,
    input wire logic [7:0] SUMMARY
);
    logic a_dl;
    logic b_dl;
    logic mapped;
    assign a_dl = |(FRAMER_A_DATALINK_PEND & ~FRAMER_A_DATALINK_MASK);
    assign b_dl = |(FRAMER_B_DATALINK_PEND & ~FRAMER_B_DATALINK_MASK);
    assign mapped = ADDR == trsf_pkg::ADDR_SUMMARY || ADDR == trsf_pkg::ADDR_INFO1_A
                    || ADDR == trsf_pkg::ADDR_INFO2_A || ADDR == trsf_pkg::ADDR_INFO1_B;
    default clocking dc @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////////////////////////////
    a_bert_summary: assert property (
        $past(RST_N) |-> SUMMARY[6] == $past(BERT_REQUEST_PENDING))
        else $error("tester summary bit wrong");
    a_framer_a_summary: assert property (
        $past(RST_N) |-> SUMMARY[2:0] == {$past(a_dl), $past(FRAMER_A_STATUS_PEND)})
        else $error("framer a summary bits wrong");
    a_framer_b_summary: assert property (
        $past(RST_N) |-> SUMMARY[5:3] == {$past(b_dl), $past(FRAMER_B_STATUS_PEND)})
        else $error("framer b summary bits wrong");
    a_info1a_spare_bits: assert property (
        RD && ADDR == trsf_pkg::ADDR_INFO1_A |=> (RDATA & ~trsf_pkg::MASK_INFO1) == 8'h00)
        else $error("first register a spare bits set");
    a_info1b_spare_bits: assert property (
        RD && ADDR == trsf_pkg::ADDR_INFO1_B |=> (RDATA & ~trsf_pkg::MASK_INFO1) == 8'h00)
        else $error("first register b spare bits set");
    a_info2_spare_bits: assert property (
        RD && ADDR == trsf_pkg::ADDR_INFO2_A |=> (RDATA & ~trsf_pkg::MASK_INFO2) == 8'h00)
        else $error("second register spare bits set");
    a_read_data_holds: assert property (
        !RD && !$past(RD) |=> $stable(RDATA))
        else $error("read data changed without a read");
    a_unmapped_reads_zero: assert property (
        RD && !mapped |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind trsf_status_flags trsf_status_flags_props i_props (.MCLK, .RST_N, .ADDR, .RD, .RDATA,
    .FRAMER_A_STATUS_PEND, .FRAMER_B_STATUS_PEND, .FRAMER_A_DATALINK_PEND,
    .FRAMER_B_DATALINK_PEND, .FRAMER_A_DATALINK_MASK, .FRAMER_B_DATALINK_MASK,
    .BERT_REQUEST_PENDING, .SUMMARY);

// ==== tb/trsf_host.sv ====
// Host processor model on the parallel control port.
`timescale 1ns/1ps
module trsf_host (
    input  wire logic       MCLK,
    input  wire logic [7:0] RDATA,
    output logic      [7:0] ADDR,
    output logic      [7:0] WDATA,
    output logic            WR,
    output logic            RD
);
    initial begin
        ADDR = 8'h00;
        WDATA = 8'h00;
        WR = 1'b0;
        RD = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
        WDATA <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        @(posedge MCLK);
        d = RDATA;
    endtask
    // Mask write, then read, which clears the seen bits, then write back what was seen.
    task automatic poll(input logic [7:0] a, input logic [7:0] m, output logic [7:0] d);
        wr(a, m);
        rd(a, d);
        wr(a, d & m);
    endtask
endmodule

// ==== tb/trsf_status_flags_tb.sv ====
// Self-checking bench of the receive status flag block.
`timescale 1ns/1ps
module trsf_status_flags_tb;
    logic       clk;
    logic       rst_n;
    logic [7:0] addr, wdata, rdata, summary, v, dpa, dpb, dma, dmb;
    logic       wr, rd, zse, bert;
    logic [1:0] bv, rp, rn, fv, fe, al, spa, spb;
    logic [3:0] alm;
    logic [7:0] mk [3] = '{8'h80, 8'h60, 8'h04};
    int         num_errors = 0;
    int         checks_done = 0;
    int         cycles = 0;
    trsf_status_flags i_dut (.MCLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .BIT_VALID_A(bv[0]), .RX_POSITIVE_IN_A(rp[0]),
        .RX_NEGATIVE_IN_A(rn[0]), .BIT_VALID_B(bv[1]), .RX_POSITIVE_IN_B(rp[1]),
        .RX_NEGATIVE_IN_B(rn[1]), .FBIT_VALID_A(fv[0]), .FBIT_ERROR_A(fe[0]),
        .FBIT_VALID_B(fv[1]), .FBIT_ERROR_B(fe[1]), .ALIGN_CHANGE_A(al[0]),
        .ALIGN_CHANGE_B(al[1]), .SYNC_LOST_A(alm[0]), .LINE_CARRIER_LOST_A(alm[1]),
        .FRAMER_CARRIER_LOST_A(alm[2]), .BLUE_ALARM_A(alm[3]), .ZERO_SUBSTITUTION_ENABLE(zse),
        .FRAMER_A_STATUS_PEND(spa), .FRAMER_B_STATUS_PEND(spb), .FRAMER_A_DATALINK_PEND(dpa),
        .FRAMER_B_DATALINK_PEND(dpb), .FRAMER_A_DATALINK_MASK(dma),
        .FRAMER_B_DATALINK_MASK(dmb), .BERT_REQUEST_PENDING(bert), .SUMMARY(summary));
    trsf_host i_host (.MCLK(clk), .RDATA(rdata), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // Full poll; bits without a meaning are dropped before comparing.
    task automatic pchk(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] k;
        k = a == trsf_pkg::ADDR_INFO2_A ? trsf_pkg::MASK_INFO2 : trsf_pkg::MASK_INFO1;
        i_host.poll(a, 8'hFF, v);
        chk(n, e, v & k);
    endtask
    // One mark, then n line bits taken from the rails, least significant first.
    task automatic line(input int s, input int n, input logic [15:0] p, input logic [15:0] q);
        bv[s] <= 1'b1;
        rp[s] <= 1'b1;
        rn[s] <= 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rp[s] <= p[i];
            rn[s] <= q[i];
        end
        @(posedge clk);
        bv[s] <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic fbits(input int s, input int n, input logic [7:0] e);
        for (int i = 0; i < n; i++) begin
            fv[s] <= 1'b1;
            fe[s] <= e[i];
            @(posedge clk);
        end
        fv[s] <= 1'b0;
        fe[s] <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {bv, rp, rn, fv, fe, al, alm, zse, bert, spa, spb} <= '0;
        {dpa, dpb, dma, dmb} <= '0;
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int b = 0; b < 7; b++) begin
            {bert, dpb[0], spb, dpa[0], spa} <= 7'h01 << b;
            repeat (2) @(posedge clk);
            chk("summary", 8'h01 << b, summary);
            i_host.rd(trsf_pkg::ADDR_SUMMARY, v);
            chk("summary read", 8'h01 << b, v);
        end
        {bert, dpb, spb, spa} <= '0;
        dpa <= 8'h81;
        dma <= 8'h81;
        repeat (2) @(posedge clk);
        chk("masked link", 8'h00, summary);
        dma <= 8'h80;
        repeat (2) @(posedge clk);
        chk("unmasked link", 8'h04, summary);
        i_host.rd(8'h00, v);
        chk("unmapped", 8'h00, v);
        line(0, 7, 16'h0, 16'h0);
        pchk("seven zeros", trsf_pkg::ADDR_INFO1_A, 8'h00);
        line(0, 8, 16'h0, 16'h0);
        pchk("eight zeros", trsf_pkg::ADDR_INFO1_A, 8'h40);
        pchk("quiet b", trsf_pkg::ADDR_INFO1_B, 8'h00);
        line(1, 16, 16'h0, 16'h0);
        pchk("sixteen zeros b", trsf_pkg::ADDR_INFO1_B, 8'h60);
        for (int e = 0; e < 2; e++) begin
            zse <= e[0];
            line(0, 8, 16'h0088, 16'h0050);
            pchk("code word", trsf_pkg::ADDR_INFO1_A, 8'h02);
        end
        fbits(0, 6, 8'h01);
        pchk("one framing error", trsf_pkg::ADDR_INFO1_A, 8'h01);
        fbits(0, 2, 8'h03);
        pchk("two framing errors", trsf_pkg::ADDR_INFO1_A, 8'h05);
        fbits(1, 2, 8'h03);
        pchk("framing errors b", trsf_pkg::ADDR_INFO1_B, 8'h05);
        al <= 2'b11;
        @(posedge clk);
        al <= 2'b00;
        repeat (6) @(posedge clk);
        pchk("align a", trsf_pkg::ADDR_INFO1_A, 8'h80);
        pchk("align b", trsf_pkg::ADDR_INFO1_B, 8'h80);
        pchk("read clears", trsf_pkg::ADDR_INFO1_A, 8'h00);
        alm <= 4'hF;
        repeat (6) @(posedge clk);
        pchk("alarms present", trsf_pkg::ADDR_INFO2_A, 8'h00);
        alm <= 4'h0;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            i_host.poll(trsf_pkg::ADDR_INFO2_A, mk[i], v);
            chk("cleared flags", mk[i], v & trsf_pkg::MASK_INFO2);
        end
        pchk("cleared flags gone", trsf_pkg::ADDR_INFO2_A, 8'h00);
        tally_and_finish();
    end
endmodule
